// [bench/line_sample_source.sv]
// Model of the measurement path feeding loop samples to the block.
// Assumes the bench pulses fire for one cycle per sample.
`timescale 1ns/1ps

module line_sample_source
(
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic fireVoltage,
    input wire logic [7:0] fireValue,
    output line_thresh_pkg::sample_t currentSample,
    output line_thresh_pkg::sample_t voltageSample
);
    // Between updates the value shows the inverse, so a design that
    // ignores the strobe sees a wrong value rather than a stale match
    always_ff @(posedge sys_clk)
    begin
        currentSample.valid <= fire && !fireVoltage;
        voltageSample.valid <= fire && fireVoltage;
        currentSample.value <= fire ? fireValue : ~fireValue;
        voltageSample.value <= fire ? fireValue : ~fireValue;
    end
endmodule

// [bench/line_threshold_interrupt_tb_top.sv]
// Self-checking bench for the line threshold interrupt block.
// Assumes the sample source model and a one-cycle read latency.
`timescale 1ns/1ps

module line_threshold_interrupt_tb_top;
    logic sys_clk;
    logic reset;
    line_thresh_pkg::reg_req_t regReq;
    logic [7:0] regRdata;
    line_thresh_pkg::sample_t currentSample;
    line_thresh_pkg::sample_t voltageSample;
    logic irqOut;
    logic [1:0] quenchCode;
    logic rxGainStep;
    logic guardDrawEnable;
    logic fire;
    logic fireVoltage;
    logic [7:0] fireValue;
    logic [31:0] seed;
    int miscompares;
    int compares;

    line_threshold_interrupt u_line_threshold_interrupt (.sys_clk(sys_clk),
        .reset(reset), .regReq(regReq), .regRdata(regRdata),
        .currentSample(currentSample), .voltageSample(voltageSample),
        .irqOut(irqOut), .quenchCode(quenchCode), .rxGainStep(rxGainStep),
        .guardDrawEnable(guardDrawEnable));

    line_sample_source u_line_sample_source (.sys_clk(sys_clk),
        .fire(fire), .fireVoltage(fireVoltage), .fireValue(fireValue),
        .currentSample(currentSample), .voltageSample(voltageSample));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Magnitude is nine bits wide so that -128 compares as 128
    function automatic logic fires(input logic dir, input logic [7:0] thr,
        input logic [7:0] v);
        logic [8:0] mag;
        mag = v[7] ? 9'h100 - {1'b0, v} : {1'b0, v};
        return dir ? (mag > {1'b0, thr}) : (mag < {1'b0, thr});
    endfunction

    task automatic give_verdict();
        $display("counts compares %0d miscompares %0d", compares,
            miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic checkByte(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        regReq <= '{8'h00, 8'h00, 1'b0, 1'b0};
    endtask

    task automatic readReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        regReq <= '{8'h00, 8'h00, 1'b0, 1'b0};
        #1;
        d = regRdata;
    endtask

    task automatic sendSample(input logic toVoltage, input logic [7:0] v);
        @(posedge sys_clk);
        fire <= 1'b1;
        fireVoltage <= toVoltage;
        fireValue <= v;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        $display("test watchdog expired");
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        logic [7:0] v;
        logic [7:0] thr;
        logic dir;
        logic src;
        logic exp;
        regReq = '0;
        fire = 1'b0;
        fireVoltage = 1'b0;
        fireValue = 8'h00;
        reset = 1'b1;
        seed = 32'd75;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
        checkByte("ctrl reset", 8'h00, d);
        readReg(line_thresh_pkg::OFS_THRESHOLD, d);
        checkByte("threshold reset", 8'h00, d);
        writeReg(line_thresh_pkg::OFS_THRESH_CTRL, 8'hff);
        readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
        checkByte("ctrl upper bits", 8'h07, d);
        for (int i = 0; i < 4; i++)
        begin
            seed = nextRand(seed);
            v = seed[7:0];
            writeReg(line_thresh_pkg::OFS_RELEASE_TIMING, v);
            readReg(line_thresh_pkg::OFS_RELEASE_TIMING, d);
            checkByte("timing rw", v & 8'h56, d);
            checkByte("timing pins", {4'h0, v[6], v[4], v[2], v[1]},
                {4'h0, quenchCode, rxGainStep, guardDrawEnable});
        end
        // Reserved range is only read, never written
        readReg(line_thresh_pkg::OFS_RSVD_FIRST, d);
        checkByte("reserved read", 8'h00, d);
        writeReg(8'hf0, 8'h5a);
        readReg(8'hf0, d);
        checkByte("unmapped read", 8'h00, d);
        $display("test registers done");
        writeReg(line_thresh_pkg::OFS_GLOBAL_CTRL, 8'h01);
        for (int i = 0; i < 40; i++)
        begin
            seed = nextRand(seed);
            {v, thr, dir, src} = {seed[23:8], seed[1:0]};
            if (i < 4)
                v = (i < 2) ? thr : 8'h80;
            if (i == 4)
                {v, thr, dir, src} = {8'hff, 8'h00, 1'b1, 1'b1};
            writeReg(line_thresh_pkg::OFS_THRESHOLD, thr);
            writeReg(line_thresh_pkg::OFS_THRESH_CTRL, {5'h00, src, 2'b10}
                | {7'h00, dir});
            sendSample(!src, dir ? 8'h80 : 8'h00);
            readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
            checkByte("unselected source", {5'h00, src, 1'b1, dir}, d);
            sendSample(src, v);
            exp = fires(dir, thr, v);
            readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
            checkByte("crossing", {4'h0, exp, src, 1'b1, dir}, d);
            checkByte("irq pin", {7'h00, exp}, {7'h00, irqOut});
            writeReg(line_thresh_pkg::OFS_THRESH_CTRL, {4'h1, src, 1'b0, dir});
            readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
            checkByte("flag kept", {4'h0, exp, src, 1'b0, dir}, d);
            checkByte("masked irq", 8'h00, {7'h00, irqOut});
            writeReg(line_thresh_pkg::OFS_THRESH_CTRL, {5'h00, src, 1'b0, dir});
            readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
            checkByte("flag cleared", {5'h00, src, 1'b0, dir}, d);
        end
        $display("test crossings done");
        writeReg(line_thresh_pkg::OFS_IRQ_MASK, 8'h08);
        readReg(line_thresh_pkg::OFS_IRQ_STATUS, d);
        writeReg(line_thresh_pkg::OFS_THRESHOLD, 8'h00);
        writeReg(line_thresh_pkg::OFS_THRESH_CTRL, 8'h01);
        sendSample(1'b0, 8'h05);
        checkByte("status irq", 8'h01, {7'h00, irqOut});
        readReg(line_thresh_pkg::OFS_IRQ_STATUS, d);
        checkByte("status read", 8'h08, d);
        readReg(line_thresh_pkg::OFS_IRQ_STATUS, d);
        checkByte("status cleared", 8'h00, d);
        checkByte("irq released", 8'h00, {7'h00, irqOut});
        readReg(line_thresh_pkg::OFS_LOOP_CURRENT, d);
        checkByte("current copy", 8'h05, d);
        $display("test status interrupt done");
        // Flag is still set here; only the global enable decides the pin
        writeReg(line_thresh_pkg::OFS_GLOBAL_CTRL, 8'h00);
        writeReg(line_thresh_pkg::OFS_THRESH_CTRL, 8'h0b);
        readReg(line_thresh_pkg::OFS_GLOBAL_CTRL, d);
        checkByte("global off", 8'h00, d);
        checkByte("global off irq", 8'h00, {7'h00, irqOut});
        writeReg(line_thresh_pkg::OFS_GLOBAL_CTRL, 8'h01);
        readReg(line_thresh_pkg::OFS_THRESH_CTRL, d);
        checkByte("flag held", 8'h0b, d);
        checkByte("global on irq", 8'h01, {7'h00, irqOut});
        $display("test global enable done");
        give_verdict();
    end
endmodule

// [hw/line_thresh_pkg.sv]
// Constants and carrier types for the line threshold interrupt block.
// Assumes a byte-wide register port with one-cycle read latency.
package line_thresh_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_LOOP_CURRENT = 8'h1c;
    localparam logic [7:0] OFS_LOOP_VOLTAGE = 8'h1d;
    localparam logic [7:0] OFS_THRESHOLD = 8'h2b;
    localparam logic [7:0] OFS_THRESH_CTRL = 8'h2c;
    localparam logic [7:0] OFS_RSVD_FIRST = 8'h2d;
    localparam logic [7:0] OFS_RSVD_LAST = 8'h3a;
    localparam logic [7:0] OFS_RELEASE_TIMING = 8'h3b;
    localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h3c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h3d;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h3e;

    // --------------------------------------------------------------
    // Field positions and reset values
    // --------------------------------------------------------------
    localparam int BIT_DIRECTION = 0;
    localparam int BIT_IRQ_MASK = 1;
    localparam int BIT_SOURCE = 2;
    localparam int BIT_CROSSED = 3;
    localparam int BIT_QUENCH_HI = 6;
    localparam int BIT_QUENCH_LO = 4;
    localparam int BIT_RX_GAIN = 2;
    localparam int BIT_GUARD_DRAW = 1;
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_SIGN = 7;
    localparam logic [7:0] CTRL_WR_MASK = 8'h0_7;
    localparam logic [7:0] TIMING_WR_MASK = 8'h5_6;
    localparam logic [7:0] RESET_ZERO = 8'h0_0;
    localparam logic [7:0] RESET_TIMING = 8'h0_0;
    localparam logic [7:0] ONE_BYTE = 8'h0_1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic valid;
    } sample_t;

endpackage

// [hw/line_threshold_interrupt.sv]
// Threshold interrupt logic of a line-side interface device.
// Assumes samples arrive on sys_clk with a one-cycle update strobe.
//
// Contract
// RL1: Crossing sets threshold-crossed flag bit 3
// RL2: Flag, mask and global enable drive interrupt
// RL3: Flag sticks until software writes zero
// RL4: Source bit 0 compares loop current
// RL5: Source bit 1 compares loop voltage
// RL6: Mask bit 1 gates pin interrupt
// RL7: Direction 0 triggers on magnitude below threshold
// RL8: Direction 1 triggers on magnitude above threshold
// RL9: Software never writes reserved range
// RL10: Release timing holds quench, gain, guard bits
// RL11: Threshold from separate register, reset zero
// RL12: Voltage is two's complement, take magnitude
// RL13: Compare on each selected sample update
// RL14: Control bits 7:4 read zero, reset zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

module line_threshold_interrupt
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire line_thresh_pkg::reg_req_t regReq,
    output logic [line_thresh_pkg::DATA_W-1:0] regRdata,
    input wire line_thresh_pkg::sample_t currentSample,
    input wire line_thresh_pkg::sample_t voltageSample,
    output logic irqOut,
    output logic [1:0] quenchCode,
    output logic rxGainStep,
    output logic guardDrawEnable
);

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------
    wire logic wrThresh;
    wire logic wrCtrl;
    wire logic wrTiming;
    wire logic wrGlobal;
    wire logic wrMask;
    wire logic rdStatus;
    wire logic [7:0] wdata;
    assign wdata = regReq.wdata;
    assign wrThresh = regReq.wr
        && regReq.addr == line_thresh_pkg::OFS_THRESHOLD;
    assign wrCtrl = regReq.wr
        && regReq.addr == line_thresh_pkg::OFS_THRESH_CTRL;
    assign wrTiming = regReq.wr
        && regReq.addr == line_thresh_pkg::OFS_RELEASE_TIMING;
    assign wrGlobal = regReq.wr
        && regReq.addr == line_thresh_pkg::OFS_GLOBAL_CTRL;
    assign wrMask = regReq.wr
        && regReq.addr == line_thresh_pkg::OFS_IRQ_MASK;
    assign rdStatus = regReq.rd
        && regReq.addr == line_thresh_pkg::OFS_IRQ_STATUS;

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [7:0] threshold_q;
    logic [2:0] ctrl_q;
    logic crossed_q;
    logic crossed_d;
    logic [7:0] timing_q;
    logic globalEn_q;
    logic status_q;
    logic status_d;
    logic mask_q;
    logic [7:0] current_q;
    logic [7:0] voltage_q;

    wire logic direction;
    wire logic srcVoltage;
    wire logic pinMask;
    assign direction = ctrl_q[line_thresh_pkg::BIT_DIRECTION];
    assign pinMask = ctrl_q[line_thresh_pkg::BIT_IRQ_MASK];
    assign srcVoltage = ctrl_q[line_thresh_pkg::BIT_SOURCE];

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            threshold_q <= line_thresh_pkg::RESET_ZERO; // RL11
            ctrl_q <= line_thresh_pkg::RESET_ZERO[2:0]; // RL14
        end
        else
        begin
            if (wrThresh)
                threshold_q <= wdata; // RL11
            if (wrCtrl)
                ctrl_q <= wdata[2:0]; // RL14
        end
    end

    // Release timing has no defined reset value; cleared for determinism.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            timing_q <= line_thresh_pkg::RESET_TIMING;
        else if (wrTiming)
            timing_q <= wdata & line_thresh_pkg::TIMING_WR_MASK; // RL10
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            globalEn_q <= 1'b0;
            mask_q <= 1'b0;
        end
        else
        begin
            if (wrGlobal)
                globalEn_q <= wdata[line_thresh_pkg::BIT_GLOBAL_EN];
            if (wrMask)
                mask_q <= wdata[line_thresh_pkg::BIT_CROSSED];
        end
    end

    // Latest measurement copies, readable by software
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            current_q <= line_thresh_pkg::RESET_ZERO;
            voltage_q <= line_thresh_pkg::RESET_ZERO;
        end
        else
        begin
            if (currentSample.valid)
                current_q <= currentSample.value;
            if (voltageSample.valid)
                voltage_q <= voltageSample.value;
        end
    end

    // --------------------------------------------------------------
    // Threshold comparison
    // --------------------------------------------------------------
    wire logic [7:0] selValue;
    wire logic selValid;
    wire logic [7:0] magnitude;
    wire logic below;
    wire logic above;
    wire logic trigger;
    assign selValue = srcVoltage ? voltageSample.value
                                 : currentSample.value; // RL4 RL5
    assign selValid = srcVoltage ? voltageSample.valid
                                 : currentSample.valid; // RL13
    // Negating -128 gives 128 back, the right magnitude as unsigned
    assign magnitude = selValue[line_thresh_pkg::BIT_SIGN]
        ? 8'(~selValue + line_thresh_pkg::ONE_BYTE) : selValue; // RL12
    assign below = magnitude < threshold_q; // RL7
    assign above = magnitude > threshold_q; // RL8
    assign trigger = selValid && (direction ? above : below); // RL13

    // --------------------------------------------------------------
    // Sticky flags: a trigger in the clearing cycle wins
    // --------------------------------------------------------------
    wire logic clrCrossed;
    assign clrCrossed = wrCtrl && !wdata[line_thresh_pkg::BIT_CROSSED];

    always_comb
    begin
        crossed_d = crossed_q;
        if (clrCrossed)
            crossed_d = 1'b0; // RL3
        if (trigger)
            crossed_d = 1'b1; // RL1
        status_d = status_q;
        if (rdStatus)
            status_d = 1'b0;
        if (trigger)
            status_d = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            crossed_q <= 1'b0;
            status_q <= 1'b0;
        end
        else
        begin
            crossed_q <= crossed_d;
            status_q <= status_d;
        end
    end

    // --------------------------------------------------------------
    // Interrupt output
    // --------------------------------------------------------------
    // Gate with next-cycle enables, so the pin moves in step with a
    // mask or enable write rather than one cycle behind it
    wire logic pinMaskD;
    wire logic globalEnD;
    wire logic statusMaskD;
    wire logic irqD;
    assign pinMaskD = wrCtrl ? wdata[line_thresh_pkg::BIT_IRQ_MASK]
                             : pinMask; // RL6
    assign globalEnD = wrGlobal ? wdata[line_thresh_pkg::BIT_GLOBAL_EN]
                                : globalEn_q; // RL2
    assign statusMaskD = wrMask ? wdata[line_thresh_pkg::BIT_CROSSED]
                                : mask_q;
    assign irqD = (crossed_d && pinMaskD && globalEnD) // RL2 RL6
        || (status_d && statusMaskD);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            irqOut <= 1'b0;
        else
            irqOut <= irqD;
    end

    // --------------------------------------------------------------
    // Read mux
    // --------------------------------------------------------------
    wire logic [7:0] ctrlView;
    wire logic [7:0] rdMux;
    assign ctrlView = {4'h0, crossed_q, ctrl_q}; // RL14
    assign rdMux =
        regReq.addr == line_thresh_pkg::OFS_THRESHOLD ? threshold_q :
        regReq.addr == line_thresh_pkg::OFS_THRESH_CTRL ? ctrlView :
        regReq.addr == line_thresh_pkg::OFS_RELEASE_TIMING ? timing_q :
        regReq.addr == line_thresh_pkg::OFS_LOOP_CURRENT ? current_q :
        regReq.addr == line_thresh_pkg::OFS_LOOP_VOLTAGE ? voltage_q :
        regReq.addr == line_thresh_pkg::OFS_GLOBAL_CTRL
            ? {7'h00, globalEn_q} :
        regReq.addr == line_thresh_pkg::OFS_IRQ_STATUS
            ? {4'h0, status_q, 3'h0} :
        regReq.addr == line_thresh_pkg::OFS_IRQ_MASK
            ? {4'h0, mask_q, 3'h0} :
        line_thresh_pkg::RESET_ZERO;

    // Reserved range reads zero; writes there are dropped (RL9 is software's)
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            regRdata <= line_thresh_pkg::RESET_ZERO;
        else if (regReq.rd)
            regRdata <= rdMux;
        else
            regRdata <= line_thresh_pkg::RESET_ZERO;
    end

    // --------------------------------------------------------------
    // Release timing outputs
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            quenchCode <= 2'b00;
            rxGainStep <= 1'b0;
            guardDrawEnable <= 1'b0;
        end
        else
        begin
            quenchCode <= {timing_q[line_thresh_pkg::BIT_QUENCH_HI],
                           timing_q[line_thresh_pkg::BIT_QUENCH_LO]}; // RL10
            rxGainStep <= timing_q[line_thresh_pkg::BIT_RX_GAIN];
            guardDrawEnable <= timing_q[line_thresh_pkg::BIT_GUARD_DRAW];
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    flag_sets_a: // RL1
    assert property (@(posedge sys_clk) disable iff (reset)
        trigger |=> crossed_q)
    else $error("crossing did not set flag");

    flag_sticky_a: // RL3
    assert property (@(posedge sys_clk) disable iff (reset)
        crossed_q && !clrCrossed |=> crossed_q)
    else $error("flag dropped without a zero write");

    flag_clear_a: // RL3
    assert property (@(posedge sys_clk) disable iff (reset)
        crossed_q && clrCrossed && !trigger |=> !crossed_q)
    else $error("zero write did not clear flag");

    irq_gated_a: // RL2
    assert property (@(posedge sys_clk) disable iff (reset)
        crossed_q && pinMask && globalEn_q |-> irqOut)
    else $error("interrupt missing");

    mask_blocks_a: // RL6
    assert property (@(posedge sys_clk) disable iff (reset)
        !pinMask && !(status_q && mask_q) |-> !irqOut)
    else $error("interrupt while masked");

    global_gate_a: // RL2
    assert property (@(posedge sys_clk) disable iff (reset)
        !globalEn_q && !(status_q && mask_q) |-> !irqOut)
    else $error("interrupt while globally disabled");

    status_set_a: // RL1
    assert property (@(posedge sys_clk) disable iff (reset)
        trigger |=> status_q)
    else $error("crossing did not set status");

    current_src_a: // RL4
    assert property (@(posedge sys_clk) disable iff (reset)
        !srcVoltage && currentSample.valid && !crossed_q
        && (direction ? currentSample.value > threshold_q
            && !currentSample.value[line_thresh_pkg::BIT_SIGN]
            : currentSample.value < threshold_q
            && !currentSample.value[line_thresh_pkg::BIT_SIGN])
        |=> crossed_q)
    else $error("current sample ignored");

    voltage_abs_a: // RL5
    assert property (@(posedge sys_clk) disable iff (reset)
        srcVoltage && voltageSample.valid
        && voltageSample.value == 8'hff && direction
        && threshold_q == 8'h00 |=> crossed_q)
    else $error("voltage magnitude not used");

    below_dir_a: // RL7
    assert property (@(posedge sys_clk) disable iff (reset)
        selValid && !direction && magnitude >= threshold_q
        && !crossed_q && !wrCtrl |=> !crossed_q)
    else $error("false trigger on low direction");

    above_dir_a: // RL8
    assert property (@(posedge sys_clk) disable iff (reset)
        selValid && direction && magnitude <= threshold_q
        && !crossed_q && !wrCtrl |=> !crossed_q)
    else $error("false trigger on high direction");

    ctrl_top_zero_a: // RL14
    assert property (@(posedge sys_clk) disable iff (reset)
        regReq.rd && regReq.addr == line_thresh_pkg::OFS_THRESH_CTRL
        |=> regRdata[7:4] == 4'h0)
    else $error("reserved control bits not zero");

endmodule
